// [rftr_params.svh]
`ifndef RFTR_PARAMS_SVH
`define RFTR_PARAMS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RFTR_ADDR_ANALOG_TEST   8'h1a
`define RFTR_ADDR_DIGITAL_TEST  8'h1b
`define RFTR_ADDR_FIFO_STATUS   8'h1c
`define RFTR_ADDR_TX_LEN_HIGH   8'h1d
`define RFTR_ADDR_TX_LEN_LOW    8'h1e
// ----------------------------------------
// Reset values and field positions
// ----------------------------------------
`define RFTR_RESET_VALUE        8'h00
`define RFTR_BIT_KEY_DEC_IN     7
`define RFTR_BIT_MOD_SUBC_OUT   6
`define RFTR_BIT_DIRECT_MOD     5
`define RFTR_BIT_STAGE_SEL      4
`define RFTR_BIT_GAIN_CUT2      3
`define RFTR_BIT_GAIN_CUT1      2
`define RFTR_BIT_FOLLOWER_TEST  1
`define RFTR_BIT_AGC_VIEW       0
`define RFTR_BIT_RF_LEVEL_TEST  7
`define RFTR_BIT_TEST_IO1       3
`define RFTR_BIT_TEST_IO0       2
`define RFTR_BIT_TEST_DEC       1
`define RFTR_BIT_CODER_FAST     0
`define RFTR_TEST_CLEAR_MASK    8'hf1
`define RFTR_FIFO_HIGH_LEVEL    4'h9
`define RFTR_FIFO_LOW_LEVEL     4'h3
`define RFTR_FIFO_DEPTH         4'hc
`endif

// [rftr_pkg.sv]
package rftr_pkg;
    typedef logic [7:0] rftr_byte_t;
endpackage

// [rftr_regs.sv]
`timescale 1ns/10ps
`default_nettype none
`include "rftr_params.svh"
// Function
// - Both test registers clear on reset or chip disable.
// - Analog bit 7 turns keying pin into decoder digital input.
// - Analog bit 6 drives receiver subcarrier on modulation pin.
// - Analog bit 5 enables direct modulation with receiver reset.
// - Analog bit 4 picks first or second stage for output.
// - Analog bit 3 cuts second stage gain and corner.
// - Analog bit 2 cuts first stage gain and corner.
// - Analog bit 0 makes main signal strength bits show gain level.
// - Decoder or I/O test bit enters test mode.
// - Test mode holds until host stop, which clears those bits.
// - Digital bit 0 clocks coders at full carrier rate.
// - FIFO status bit 7 reads zero.
// - Receive: high flag at nine bytes held.
// - Transmit: low flag at three bytes left.
// - Overflow flag on writes beyond FIFO capacity.
// - Low nibble reports unread bytes minus one.
// - Length registers clear on reset and at end of transmit frame.
// - Twelve-bit byte count split high byte and upper nibble.
// - Partial bit count used only when partial flag set.
// - Low length bit 0 marks incomplete final byte.
module rftr_regs (
    input  wire logic       clock_in,          // 10 MHz clock
    input  wire logic       arst_n_in,         // Async reset, low
    input  wire logic       chip_en_in,        // Chip enable pin (async)
    input  wire logic       wr_en_in,          // Host write strobe
    input  wire logic       rd_en_in,          // Host read strobe
    input  wire logic [7:0] addr_in,           // Register address
    input  wire logic [7:0] wdata_in,          // Write data
    input  wire logic       host_stop_in,      // Host stop condition pulse
    input  wire logic       tx_eof_in,         // End of transmit frame pulse
    input  wire logic       rx_active_in,      // Receive phase
    input  wire logic       tx_active_in,      // Transmit phase
    input  wire logic [3:0] fifo_count_in,     // Bytes held in FIFO
    input  wire logic       fifo_push_in,      // FIFO write pulse
    input  wire logic [2:0] rssi_main_in,      // Main signal strength
    input  wire logic [2:0] agc_level_in,      // Gain control level
    input  wire logic       keying_mode_pin_in,// Keying pin input
    input  wire logic       rx_subcarrier_in,  // Receiver subcarrier
    input  wire logic       tx_mod_in,         // Coder modulation
    output logic [7:0]      rdata_out,         // Read data
    output logic            rdata_valid_out,   // Read data valid
    output logic            keying_pin_as_decoder_input_out, // Pin mode
    output logic            decoder_input_out, // Decoder digital input
    output logic            modulation_pin_out,// Modulation pin level
    output logic            mod_pin_subcarrier_out, // Pin mode
    output logic            direct_tx_mod_rx_reset_out, // Direct mode
    output logic            rx_reset_out,      // Receiver reset
    output logic            stage_select_out,  // 1 = second stage
    output logic            second_stage_gain_cut_out, // Gain cut 2
    output logic            first_stage_gain_cut_out,  // Gain cut 1
    output logic [2:0]      rssi_main_view_out,// Strength or gain view
    output logic            test_mode_out,     // Test mode active
    output logic            coder_fast_clock_out, // Full-rate coders
    output logic [11:0]     tx_byte_count_out, // Complete bytes
    output logic [2:0]      partial_byte_bit_count_out, // Used bits
    output logic            partial_byte_flag_out // Partial byte
);
    // ----------------------------------------
    // Synchronisers for pins
    // ----------------------------------------
    logic [1:0] en_sync_ff;
    logic [1:0] key_sync_ff;
    logic [1:0] nxt_en_sync;
    logic [1:0] nxt_key_sync;
    logic       chip_off;
    // Only the second stage is read downstream
    always_comb begin
        nxt_en_sync  = {en_sync_ff[0], chip_en_in};
        nxt_key_sync = {key_sync_ff[0], keying_mode_pin_in};
    end
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            en_sync_ff  <= 2'h0;
            key_sync_ff <= 2'h0;
        end else begin
            en_sync_ff  <= nxt_en_sync;
            key_sync_ff <= nxt_key_sync;
        end
    end
    assign chip_off = ~en_sync_ff[1];

    // ----------------------------------------
    // Register write logic
    // ----------------------------------------
    rftr_pkg::rftr_byte_t analog_test_direct_ctrl_ff;
    rftr_pkg::rftr_byte_t digital_test_mode_ctrl_ff;
    rftr_pkg::rftr_byte_t tx_byte_count_high_ff;
    rftr_pkg::rftr_byte_t tx_byte_count_low_partial_ff;
    logic                 ovf_ff;
    rftr_pkg::rftr_byte_t nxt_analog;
    rftr_pkg::rftr_byte_t nxt_digital;
    rftr_pkg::rftr_byte_t nxt_txh;
    rftr_pkg::rftr_byte_t nxt_txl;
    logic                 nxt_ovf;
    logic                 rd_status;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    assign rd_status = rd_en_in & hit(addr_in, `RFTR_ADDR_FIFO_STATUS);

    // Stop and frame end win over a same-cycle host write
    always_comb begin
        nxt_analog  = analog_test_direct_ctrl_ff;
        nxt_digital = digital_test_mode_ctrl_ff;
        nxt_txh     = tx_byte_count_high_ff;
        nxt_txl     = tx_byte_count_low_partial_ff;
        nxt_ovf     = ovf_ff;
        if (wr_en_in) begin
            if (hit(addr_in, `RFTR_ADDR_ANALOG_TEST))
                nxt_analog = wdata_in;
            if (hit(addr_in, `RFTR_ADDR_DIGITAL_TEST))
                nxt_digital = wdata_in;
            if (hit(addr_in, `RFTR_ADDR_TX_LEN_HIGH))
                nxt_txh = wdata_in;
            if (hit(addr_in, `RFTR_ADDR_TX_LEN_LOW))
                nxt_txl = wdata_in;
        end
        if (host_stop_in)
            nxt_digital = nxt_digital & `RFTR_TEST_CLEAR_MASK;
        if (tx_eof_in) begin
            nxt_txh = `RFTR_RESET_VALUE;
            nxt_txl = `RFTR_RESET_VALUE;
        end
        // Overflow is sticky until status is read; set wins over clear
        if (rd_status)
            nxt_ovf = 1'b0;
        if (fifo_push_in && (fifo_count_in >= `RFTR_FIFO_DEPTH))
            nxt_ovf = 1'b1;
        if (chip_off) begin
            nxt_analog  = `RFTR_RESET_VALUE;
            nxt_digital = `RFTR_RESET_VALUE;
            nxt_txh     = `RFTR_RESET_VALUE;
            nxt_txl     = `RFTR_RESET_VALUE;
            nxt_ovf     = 1'b0;
        end
    end
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            analog_test_direct_ctrl_ff   <= `RFTR_RESET_VALUE;
            digital_test_mode_ctrl_ff    <= `RFTR_RESET_VALUE;
            tx_byte_count_high_ff        <= `RFTR_RESET_VALUE;
            tx_byte_count_low_partial_ff <= `RFTR_RESET_VALUE;
            ovf_ff                       <= 1'b0;
        end else begin
            analog_test_direct_ctrl_ff   <= nxt_analog;
            digital_test_mode_ctrl_ff    <= nxt_digital;
            tx_byte_count_high_ff        <= nxt_txh;
            tx_byte_count_low_partial_ff <= nxt_txl;
            ovf_ff                       <= nxt_ovf;
        end
    end

    // ----------------------------------------
    // Live FIFO status and read mux
    // ----------------------------------------
    rftr_pkg::rftr_byte_t status_now;
    rftr_pkg::rftr_byte_t nxt_rdata;
    logic                 nxt_rvalid;
    // Count of zero also reads zero; minus one cannot go negative
    always_comb begin
        status_now[7]   = 1'b0;
        status_now[6]   = rx_active_in &&
                          (fifo_count_in >= `RFTR_FIFO_HIGH_LEVEL);
        status_now[5]   = tx_active_in &&
                          (fifo_count_in <= `RFTR_FIFO_LOW_LEVEL);
        status_now[4]   = ovf_ff;
        status_now[3:0] = (fifo_count_in == 4'h0) ? 4'h0
                          : fifo_count_in - 4'h1;
        nxt_rvalid = rd_en_in;
        nxt_rdata  = 8'h00;
        if (rd_en_in) begin
            case (addr_in)
                `RFTR_ADDR_ANALOG_TEST: nxt_rdata = analog_test_direct_ctrl_ff;
                `RFTR_ADDR_DIGITAL_TEST: nxt_rdata = digital_test_mode_ctrl_ff;
                `RFTR_ADDR_FIFO_STATUS:  nxt_rdata = status_now;
                `RFTR_ADDR_TX_LEN_HIGH:  nxt_rdata = tx_byte_count_high_ff;
                `RFTR_ADDR_TX_LEN_LOW:
                    nxt_rdata = tx_byte_count_low_partial_ff;
                default:                 nxt_rdata = 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // Decoded control outputs
    // ----------------------------------------
    rftr_pkg::rftr_byte_t a;
    rftr_pkg::rftr_byte_t d;
    logic [7:0]  nxt_pins;
    logic [2:0]  nxt_view;
    logic        nxt_test;
    logic [11:0] nxt_count;
    logic [2:0]  nxt_bits;
    logic        nxt_pflag;
    assign a = analog_test_direct_ctrl_ff;
    assign d = digital_test_mode_ctrl_ff;
    // Pin outputs are registered, so a one-cycle lag versus the signals
    always_comb begin
        nxt_pins[0] = a[`RFTR_BIT_KEY_DEC_IN];
        nxt_pins[1] = a[`RFTR_BIT_KEY_DEC_IN] & key_sync_ff[1];
        nxt_pins[2] = a[`RFTR_BIT_MOD_SUBC_OUT];
        nxt_pins[3] = a[`RFTR_BIT_DIRECT_MOD];
        nxt_pins[4] = a[`RFTR_BIT_DIRECT_MOD];
        nxt_pins[5] = a[`RFTR_BIT_STAGE_SEL];
        nxt_pins[6] = a[`RFTR_BIT_GAIN_CUT2];
        nxt_pins[7] = a[`RFTR_BIT_GAIN_CUT1];
        nxt_view = a[`RFTR_BIT_AGC_VIEW] ? agc_level_in : rssi_main_in;
        nxt_test = d[`RFTR_BIT_TEST_DEC] | d[`RFTR_BIT_TEST_IO1]
                 | d[`RFTR_BIT_TEST_IO0];
        nxt_count = {tx_byte_count_high_ff,
                     tx_byte_count_low_partial_ff[7:4]};
        nxt_bits = tx_byte_count_low_partial_ff[0]
                 ? tx_byte_count_low_partial_ff[3:1] : 3'h0;
        nxt_pflag = tx_byte_count_low_partial_ff[0];
    end
    logic mod_level;
    // Subcarrier out has priority over direct modulation
    always_comb begin
        if (a[`RFTR_BIT_MOD_SUBC_OUT])
            mod_level = rx_subcarrier_in;
        else if (a[`RFTR_BIT_DIRECT_MOD])
            mod_level = tx_mod_in;
        else
            mod_level = 1'b0;
    end
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_out                       <= 8'h00;
            rdata_valid_out                 <= 1'b0;
            keying_pin_as_decoder_input_out <= 1'b0;
            decoder_input_out               <= 1'b0;
            mod_pin_subcarrier_out          <= 1'b0;
            direct_tx_mod_rx_reset_out      <= 1'b0;
            rx_reset_out                    <= 1'b0;
            stage_select_out                <= 1'b0;
            second_stage_gain_cut_out       <= 1'b0;
            first_stage_gain_cut_out        <= 1'b0;
            modulation_pin_out              <= 1'b0;
            rssi_main_view_out              <= 3'h0;
            test_mode_out                   <= 1'b0;
            coder_fast_clock_out            <= 1'b0;
            tx_byte_count_out               <= 12'h000;
            partial_byte_bit_count_out      <= 3'h0;
            partial_byte_flag_out           <= 1'b0;
        end else begin
            rdata_out                       <= nxt_rdata;
            rdata_valid_out                 <= nxt_rvalid;
            keying_pin_as_decoder_input_out <= nxt_pins[0];
            decoder_input_out               <= nxt_pins[1];
            mod_pin_subcarrier_out          <= nxt_pins[2];
            direct_tx_mod_rx_reset_out      <= nxt_pins[3];
            rx_reset_out                    <= nxt_pins[4];
            stage_select_out                <= nxt_pins[5];
            second_stage_gain_cut_out       <= nxt_pins[6];
            first_stage_gain_cut_out        <= nxt_pins[7];
            modulation_pin_out              <= mod_level;
            rssi_main_view_out              <= nxt_view;
            test_mode_out                   <= nxt_test;
            coder_fast_clock_out            <= d[`RFTR_BIT_CODER_FAST];
            tx_byte_count_out               <= nxt_count;
            partial_byte_bit_count_out      <= nxt_bits;
            partial_byte_flag_out           <= nxt_pflag;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_stop_clears;
        @(posedge clock_in) disable iff (!arst_n_in)
        host_stop_in |=> !digital_test_mode_ctrl_ff[1]
                         && !digital_test_mode_ctrl_ff[2]
                         && !digital_test_mode_ctrl_ff[3];
    endproperty
    a_stop_clears: assert property (p_stop_clears)
        else $error("test bits survive stop");
    property p_eof_clears;
        @(posedge clock_in) disable iff (!arst_n_in)
        tx_eof_in |=> ##1 tx_byte_count_out == 12'h000;
    endproperty
    a_eof_clears: assert property (p_eof_clears)
        else $error("length not cleared at frame end");
    property p_test_mode;
        @(posedge clock_in) disable iff (!arst_n_in)
        $rose(digital_test_mode_ctrl_ff[1]) |=> test_mode_out;
    endproperty
    a_test_mode: assert property (p_test_mode)
        else $error("test mode not entered");
    property p_partial_gate;
        @(posedge clock_in) disable iff (!arst_n_in)
        !partial_byte_flag_out |-> partial_byte_bit_count_out == 3'h0;
    endproperty
    a_partial_gate: assert property (p_partial_gate)
        else $error("bit count without flag");
    property p_read_status;
        @(posedge clock_in) disable iff (!arst_n_in)
        rd_status |=> rdata_valid_out && !rdata_out[7]
                      && rdata_out[4] == $past(ovf_ff);
    endproperty
    a_read_status: assert property (p_read_status)
        else $error("status read wrong");
    property p_ovf_set;
        @(posedge clock_in) disable iff (!arst_n_in)
        (fifo_push_in && fifo_count_in >= 4'hc && en_sync_ff[1]) |=> ovf_ff;
    endproperty
    a_ovf_set: assert property (p_ovf_set)
        else $error("overflow missed");
    property p_chip_off;
        @(posedge clock_in) disable iff (!arst_n_in)
        chip_off |=> analog_test_direct_ctrl_ff == 8'h00 ##1
                     !first_stage_gain_cut_out;
    endproperty
    a_chip_off: assert property (p_chip_off)
        else $error("disable did not clear");
    property p_agc_view;
        @(posedge clock_in) disable iff (!arst_n_in)
        a[0] |=> rssi_main_view_out == $past(agc_level_in);
    endproperty
    a_agc_view: assert property (p_agc_view)
        else $error("gain view wrong");
endmodule
`default_nettype wire

// [rftr_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
`include "rftr_params.svh"
// ----------------------------------------
// Host model: strobed register access
// ----------------------------------------
module rftr_host_model (
    input  wire logic       clock_in,       // Shared clock
    input  wire logic [7:0] rdata_in,       // Read data
    input  wire logic       rdata_valid_in, // Read answer
    output var  logic       wr_en_out,      // Write strobe
    output var  logic       rd_en_out,      // Read strobe
    output var  logic [7:0] addr_out,       // Address
    output var  logic [7:0] wdata_out       // Write data
);
    // Idle bus from time zero
    initial begin
        wr_en_out = 1'b0;
        rd_en_out = 1'b0;
        addr_out  = 8'h00;
        wdata_out = 8'h00;
    end
    // Released lines flip so a stale value never passes for a live one
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        wr_en_out <= 1'b1;
        addr_out  <= a;
        wdata_out <= d;
        @(posedge clock_in);
        wr_en_out <= 1'b0;
        addr_out  <= ~a;
        wdata_out <= ~d;
    endtask
    // Answer polled over a bounded number of cycles
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d,
                            output bit ok);
        ok = 1'b0;
        d  = 8'hxx;
        @(posedge clock_in);
        rd_en_out <= 1'b1;
        addr_out  <= a;
        @(posedge clock_in);
        rd_en_out <= 1'b0;
        addr_out  <= ~a;
        for (int i = 0; i < 3 && !ok; i++) begin
            #1;
            if (rdata_valid_in === 1'b1) begin
                ok = 1'b1;
                d  = rdata_in;
            end else begin
                @(posedge clock_in);
            end
        end
    endtask
    // High count bits first, then low nibble with the partial-byte field
    task automatic write_tx_len(input logic [11:0] n, input logic [2:0] b,
                                input logic f);
        write_reg(`RFTR_ADDR_TX_LEN_HIGH, n[11:4]);
        write_reg(`RFTR_ADDR_TX_LEN_LOW, {n[3:0], b, f});
    endtask
endmodule
`default_nettype wire

// [test_rftr_regs.sv]
`timescale 1ns/10ps
`default_nettype none
`include "rftr_params.svh"
// ----------------------------------------
// Bench: host model, pin stimulus, register model
// ----------------------------------------
module test_rftr_regs;
    logic        clock_in, arst_n, chip_en, rx_act, tx_act, key_pin, subc;
    logic        tx_mod, wr, rd, rvalid, kdec, dec_in, mod_pin, msub, dmod;
    logic        rxr, ssel, cut2, cut1, tmode, cfast, pflag;
    logic [2:0]  ev, rssi, agc, rview, pbits;
    logic [3:0]  fcnt;
    logic [7:0]  addr, wdata, rdata;
    logic [11:0] txcnt;
    int          mdl [5];
    int          bad_count, samples_checked;

    rftr_regs rftr_regs_inst (
        .clock_in(clock_in), .arst_n_in(arst_n), .chip_en_in(chip_en),
        .wr_en_in(wr), .rd_en_in(rd), .addr_in(addr), .wdata_in(wdata),
        .host_stop_in(ev[0]), .tx_eof_in(ev[1]), .fifo_push_in(ev[2]),
        .rx_active_in(rx_act), .tx_active_in(tx_act), .fifo_count_in(fcnt),
        .rssi_main_in(rssi), .agc_level_in(agc), .keying_mode_pin_in(key_pin),
        .rx_subcarrier_in(subc), .tx_mod_in(tx_mod), .rdata_out(rdata),
        .rdata_valid_out(rvalid), .keying_pin_as_decoder_input_out(kdec),
        .decoder_input_out(dec_in), .modulation_pin_out(mod_pin),
        .mod_pin_subcarrier_out(msub), .direct_tx_mod_rx_reset_out(dmod),
        .rx_reset_out(rxr), .stage_select_out(ssel),
        .second_stage_gain_cut_out(cut2), .first_stage_gain_cut_out(cut1),
        .rssi_main_view_out(rview), .test_mode_out(tmode),
        .coder_fast_clock_out(cfast), .tx_byte_count_out(txcnt),
        .partial_byte_bit_count_out(pbits), .partial_byte_flag_out(pflag)
    );
    rftr_host_model host_inst (
        .clock_in(clock_in), .rdata_in(rdata), .rdata_valid_in(rvalid),
        .wr_en_out(wr), .rd_en_out(rd), .addr_out(addr), .wdata_out(wdata)
    );

    // 10 MHz clock
    always #50 clock_in = ~clock_in;

    // Comparison, reads and event pulses
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        bit         ok;
        host_inst.read_reg(a, d, ok);
        check(16'(ok ? d : 8'hxx), 16'(e));
    endtask
    task automatic rd_all();
        for (int a = 0; a < 5; a++) begin
            if (a != 2) begin
                rd_chk(8'(8'h1a + a), 8'(mdl[a]));
            end
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock_in);
        #1;
    endtask
    task automatic pulse(input int k);
        @(posedge clock_in);
        ev[k] <= 1'b1;
        @(posedge clock_in);
        ev <= 3'h0;
        settle(3);
    endtask
    function automatic logic [7:0] stat_exp(int c, int rx, int tx, int ov);
        return {1'b0, rx != 0 && c >= 9, tx != 0 && c <= 3, ov != 0,
                c == 0 ? 4'h0 : 4'(c - 1)};
    endfunction
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run of about 600 cycles
    initial begin
        #2000000;
        bad_count++;
        test_done();
    end

    // Main sequence
    initial begin
        logic [7:0]  v;
        logic [11:0] n;
        logic [2:0]  b;
        logic        f;
        clock_in = 1'b0;
        arst_n   = 1'b0;
        chip_en  = 1'b1;
        ev       = 3'h0;
        rx_act   = 1'b0;
        tx_act   = 1'b0;
        fcnt     = 4'h0;
        {key_pin, subc, tx_mod, rssi, agc} = 9'h000;
        foreach (mdl[i]) mdl[i] = 0;
        void'($urandom(96971));
        repeat (8) @(posedge clock_in);
        arst_n <= 1'b1;
        settle(4);
        rd_all();
        rd_chk(`RFTR_ADDR_FIFO_STATUS, 8'h00);
        // Each analog control bit alone, then random mixes and pin levels
        for (int i = 0; i < 14; i++) begin
            v = (i < 8) ? 8'h01 << i : 8'($urandom);
            host_inst.write_reg(`RFTR_ADDR_ANALOG_TEST, v);
            mdl[0] = v;
            {key_pin, subc, tx_mod, rssi, agc} <= 9'($urandom);
            settle(4);
            check(16'({kdec, msub, dmod}), 16'(v[7:5]));
            check(16'({ssel, cut2, cut1}), 16'(v[4:2]));
            check(16'({rxr, dec_in, mod_pin}),
                  16'({v[5], v[7] & key_pin, v[6] ? subc : v[5] & tx_mod}));
            check(16'(rview), 16'(v[0] ? agc : rssi));
            rd_chk(`RFTR_ADDR_ANALOG_TEST, v);
        end
        // Test bits enter test mode; host stop clears only those bits
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 8'hff : 8'($urandom);
            host_inst.write_reg(`RFTR_ADDR_DIGITAL_TEST, v);
            settle(3);
            check(16'({tmode, cfast}), 16'({|v[3:1], v[0]}));
            rd_chk(`RFTR_ADDR_DIGITAL_TEST, v);
            pulse(0);
            mdl[1] = v & `RFTR_TEST_CLEAR_MASK;
            check(16'(tmode), 16'h0000);
            rd_chk(`RFTR_ADDR_DIGITAL_TEST, 8'(mdl[1]));
        end
        // Every occupancy; host writes to status must not stick
        for (int c = 0; c <= 12; c++) begin
            @(posedge clock_in);
            fcnt   <= 4'(c);
            rx_act <= 1'(c % 2);
            tx_act <= 1'(1 - c % 2);
            host_inst.write_reg(`RFTR_ADDR_FIFO_STATUS, 8'hff);
            settle(2);
            rd_chk(`RFTR_ADDR_FIFO_STATUS,
                   stat_exp(c, c % 2, 1 - c % 2, 0));
        end
        // Push at 11 fits, push at 12 overflows; a status read clears it
        for (int c = 11; c <= 12; c++) begin
            @(posedge clock_in);
            fcnt <= 4'(c);
            pulse(2);
            rd_chk(`RFTR_ADDR_FIFO_STATUS, stat_exp(c, 0, 1, c - 11));
        end
        rd_chk(`RFTR_ADDR_FIFO_STATUS, stat_exp(12, 0, 1, 0));
        // Length fields, partial flag both ways, end of frame clears
        for (int i = 0; i < 8; i++) begin
            n = 12'($urandom);
            b = (i == 0) ? 3'h5 : 3'($urandom);
            f = (i < 2) ? 1'(i) : 1'($urandom);
            host_inst.write_tx_len(n, b, f);
            mdl[3] = n[11:4];
            mdl[4] = {n[3:0], b, f};
            settle(3);
            check(16'(txcnt), 16'(n));
            check(16'({pflag, pbits}), 16'({f, f ? b : 3'h0}));
            rd_all();
            if (i % 2 == 1) begin
                pulse(1);
                mdl[3] = 0;
                mdl[4] = 0;
                check(16'(txcnt), 16'h0000);
                rd_all();
            end
        end
        // Unmapped places read zero and ignore writes
        host_inst.write_reg(8'h1f, 8'hff);
        rd_chk(8'h1f, 8'h00);
        rd_chk(8'h19, 8'h00);
        // Chip disable clears every register
        host_inst.write_reg(`RFTR_ADDR_DIGITAL_TEST, 8'h81);
        host_inst.write_tx_len(12'h5a5, 3'h3, 1'b1);
        chip_en <= 1'b0;
        settle(5);
        @(posedge clock_in);
        chip_en <= 1'b1;
        settle(5);
        foreach (mdl[i]) mdl[i] = 0;
        rd_all();
        check(16'({tmode, cfast, txcnt}), 16'h0000);
        // Mid-run reset pulse clears a freshly written control byte
        host_inst.write_reg(`RFTR_ADDR_ANALOG_TEST, 8'hff);
        settle(3);
        check(16'({ssel, cut2, cut1}), 16'h0007);
        @(posedge clock_in);
        arst_n <= 1'b0;
        settle(3);
        @(posedge clock_in);
        arst_n <= 1'b1;
        settle(4);
        rd_chk(`RFTR_ADDR_ANALOG_TEST, 8'h00);
        check(16'({kdec, msub, dmod, ssel, cut1}), 16'h0000);
        test_done();
    end
endmodule
`default_nettype wire
